// [src/sble_pkg.sv]
// constants, types and state codes shared by the serial boot loader entry block
package sble_pkg;
  localparam logic [23:0] FLASH_SEG0_LO = 24'h000000;
  localparam logic [23:0] FLASH_SEG0_HI = 24'h007fff;
  localparam logic [23:0] FLASH_SEG1_LO = 24'h010000;
  localparam logic [23:0] FLASH_SEG1_HI = 24'h017fff;
  localparam logic [23:0] LOAD_RAM_BASE = 24'h00fa40;
  localparam logic [23:0] LOAD_RAM_LAST = 24'h00fa5f;
  localparam logic [5:0] LOAD_BYTES = 6'h20;
  localparam logic [15:0] SYSCFG_LOADER = 16'h0e00;
  localparam logic [15:0] SERCTL_LOADER = 16'h8011;
  localparam logic [15:0] REGBANK_LOADER = 16'hfa00;
  localparam logic [15:0] STACK_LOADER = 16'hfa40;
  localparam logic [15:0] STKOVF_LOADER = 16'hfa0c;
  localparam logic [15:0] CFG_NORMAL = 16'h0000;
  localparam logic [15:0] RELOAD_SUB = 16'h0024;
  localparam logic [15:0] RELOAD_DIV = 16'h0048;
  localparam logic [15:0] TIMER_MAX = 16'hffff;
  localparam logic [1:0] TIMER_PRESCALE_LAST = 2'h3;
  localparam int unsigned BAUD_SHIFT = 5;
  localparam logic [3:0] FRAME_DATA_BITS = 4'h8;

  typedef enum logic [1:0] {
    ROUTE_FLASH = 2'b00,
    ROUTE_BOOT_ROM = 2'b01,
    ROUTE_EXTERNAL = 2'b10,
    ROUTE_UNDEF = 2'b11
  } sble_route_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0000,
    ST_WAIT_IDLE = 4'b0001,
    ST_WAIT_START = 4'b0010,
    ST_MEASURE = 4'b0011,
    ST_TX = 4'b0100,
    ST_RX_IDLE = 4'b0101,
    ST_RX_START = 4'b0110,
    ST_RX_BITS = 4'b0111,
    ST_RX_STOP = 4'b1000,
    ST_DRAIN = 4'b1001,
    ST_JUMP = 4'b1010,
    ST_DONE = 4'b1011
  } sble_state_t;

  typedef struct packed {
    logic [15:0] system_configuration;
    logic [15:0] serial_control;
    logic [15:0] register_bank_base;
    logic [15:0] stack_pointer;
    logic [15:0] stack_underflow_limit;
    logic [15:0] stack_overflow_limit;
  } sble_cfg_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } sble_ram_wr_t;
endpackage : sble_pkg

// [src/sble_buf2.sv]
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
`default_nettype none
module sble_buf2 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_valid,
  output logic s_ready,
  input wire sble_pkg::sble_ram_wr_t s_data,
  output logic m_valid,
  input wire logic m_ready,
  output sble_pkg::sble_ram_wr_t m_data
);
  import sble_pkg::*;

  logic out_valid_r;
  sble_ram_wr_t out_data_r;
  logic skid_valid_r;
  sble_ram_wr_t skid_data_r;
  wire out_free = m_ready || !out_valid_r;
  wire take = s_valid && s_ready;

  assign s_ready = !skid_valid_r;
  assign m_valid = out_valid_r;
  assign m_data = out_data_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_valid_r <= 1'b0;
      skid_valid_r <= 1'b0;
      out_data_r <= '0;
      skid_data_r <= '0;
    end else if (out_free) begin
      if (skid_valid_r) begin
        out_data_r <= skid_data_r;
        skid_valid_r <= 1'b0;
      end else begin
        out_valid_r <= take;
        out_data_r <= s_data;
      end
    end else if (take) begin
      skid_data_r <= s_data;
      skid_valid_r <= 1'b1;
    end
  end
endmodule : sble_buf2
`default_nettype wire

// [src/sble_boot_loader.sv]
// serial boot loader entry: strap capture, baud measurement, id reply, start-up load, fetch routing
`timescale 1ns/1ps
`default_nettype none
module sble_boot_loader #(
  parameter logic [7:0] ID_BYTE = 8'h5a // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sw_reset,
  input wire logic boot_select_pin,
  input wire logic external_access_pin,
  input wire logic flash_seg1_map,
  input wire logic prog_mem_present,
  input wire logic boot_serial_rx_line,
  output logic boot_serial_tx_line,
  output logic tx_pin_direction_bit,
  output logic boot_loader_mode,
  output logic watchdog_disable,
  output sble_pkg::sble_cfg_t cfg,
  output logic [15:0] baud_reload_value,
  output logic baud_overflow,
  input wire logic fetch_valid,
  input wire logic fetch_is_code,
  input wire logic [23:0] fetch_addr,
  output sble_pkg::sble_route_t fetch_route,
  output logic fetch_route_valid,
  output logic ram_wr_valid,
  input wire logic ram_wr_ready,
  output sble_pkg::sble_ram_wr_t ram_wr,
  output logic jump_req,
  output logic [23:0] jump_addr
);
  import sble_pkg::*;

  function automatic logic [15:0] calc_reload(input logic [15:0] t);
    logic [15:0] d;
    d = (t > RELOAD_SUB) ? t - RELOAD_SUB : 16'h0000;
    return d / RELOAD_DIV;
  endfunction : calc_reload

  function automatic logic [20:0] bit_clks(input logic [15:0] brl);
    logic [20:0] w;
    w = {5'h00, brl} + 21'h000001;
    return w << BAUD_SHIFT;
  endfunction : bit_clks

  logic rel_pend_r, mode_r, mode_nxt;
  sble_state_t st_r, st_nxt;
  logic [1:0] pre_r;
  logic [15:0] t6_r, brl_r;
  logic ovf_r;
  logic [20:0] clk_cnt_r;
  logic [3:0] bit_r;
  logic [9:0] sh_r;
  logic [5:0] idx_r;
  logic rx_prev_r, tx_r, pend_r, jump_r;
  logic [23:0] jump_addr_r;
  logic [7:0] rxb_r;
  sble_ram_wr_t pend_data_r;
  sble_route_t route_r;
  logic route_v_r;
  sble_cfg_t cfg_r;
  logic buf_s_ready;

  wire [20:0] period = bit_clks(brl_r);
  wire [20:0] half_period = period >> 1;
  wire period_done = (clk_cnt_r == period - 21'h000001);
  wire half_done = (clk_cnt_r == half_period);
  wire rx_fall = rx_prev_r && !boot_serial_rx_line;
  wire t6_tick = (pre_r == TIMER_PRESCALE_LAST);
  wire t6_full = (t6_r == TIMER_MAX);

  // flash window moves with the segment-1 mapping
  wire in_seg0 = (fetch_addr >= FLASH_SEG0_LO) && (fetch_addr <= FLASH_SEG0_HI);
  wire in_seg1 = (fetch_addr >= FLASH_SEG1_LO) && (fetch_addr <= FLASH_SEG1_HI);
  wire in_flash = flash_seg1_map ? in_seg1 : in_seg0;
  // loader mode: code to boot ROM, data to flash or undefined, ext pin unused
  wire sble_route_t loader_route = fetch_is_code ? ROUTE_BOOT_ROM :
      (prog_mem_present ? ROUTE_FLASH : ROUTE_UNDEF);
  wire sble_route_t normal_route = external_access_pin ? ROUTE_FLASH : ROUTE_EXTERNAL;
  wire sble_route_t route_nxt = !in_flash ? ROUTE_EXTERNAL :
      (mode_r ? loader_route : normal_route);

  // strap caught at the first edge after release; bus mode plays no part
  assign mode_nxt = sw_reset ? 1'b0 :
      (rel_pend_r ? !boot_select_pin : mode_r);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_OFF: if (rel_pend_r && !boot_select_pin) st_nxt = ST_WAIT_IDLE;
      ST_WAIT_IDLE: if (boot_serial_rx_line) st_nxt = ST_WAIT_START;
      ST_WAIT_START: if (rx_fall) st_nxt = ST_MEASURE;
      ST_MEASURE: begin
        if (t6_full && t6_tick) st_nxt = ST_WAIT_IDLE;
        else if (boot_serial_rx_line) st_nxt = ST_TX;
      end
      ST_TX: if (period_done && bit_r == FRAME_DATA_BITS + 4'h1) st_nxt = ST_RX_IDLE;
      ST_RX_IDLE: begin
        if (idx_r == LOAD_BYTES) st_nxt = ST_DRAIN;
        else if (rx_fall && !pend_r) st_nxt = ST_RX_START;
      end
      ST_RX_START: if (half_done) st_nxt = boot_serial_rx_line ? ST_RX_IDLE : ST_RX_BITS;
      ST_RX_BITS: if (period_done && bit_r == FRAME_DATA_BITS - 4'h1) st_nxt = ST_RX_STOP;
      ST_RX_STOP: if (period_done) st_nxt = ST_RX_IDLE;
      ST_DRAIN: if (!pend_r && !ram_wr_valid) st_nxt = ST_JUMP;
      ST_JUMP: st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_DONE;
      default: st_nxt = ST_OFF;
    endcase
    if (sw_reset) st_nxt = ST_OFF;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rel_pend_r <= 1'b1;
      mode_r <= 1'b0;
      st_r <= ST_OFF;
      rx_prev_r <= 1'b1;
    end else begin
      rel_pend_r <= 1'b0;
      mode_r <= mode_nxt;
      st_r <= st_nxt;
      rx_prev_r <= boot_serial_rx_line;
    end
  end

  // zero-byte length in prescaled timer ticks, reload derived on the rising stop edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b || st_r != ST_MEASURE) begin
      pre_r <= '0;
      t6_r <= '0;
    end else begin
      pre_r <= pre_r + 2'h1;
      if (t6_tick && !t6_full) t6_r <= t6_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      brl_r <= '0;
      ovf_r <= 1'b0;
    end else if (st_r == ST_MEASURE && st_nxt == ST_TX) begin
      brl_r <= calc_reload(t6_r);
      ovf_r <= 1'b0;
    end else if (st_r == ST_MEASURE && st_nxt == ST_WAIT_IDLE) begin
      ovf_r <= 1'b1;
    end
  end

  // bit-time counter shared by the transmitter and receiver
  always_ff @(posedge sys_clk) begin
    if (!rst_b || st_r != st_nxt || period_done) clk_cnt_r <= '0;
    else clk_cnt_r <= clk_cnt_r + 21'h000001;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bit_r <= '0;
      sh_r <= '1;
      tx_r <= 1'b1;
      rxb_r <= '0;
    end else if (st_r == ST_MEASURE && st_nxt == ST_TX) begin
      sh_r <= {1'b1, ID_BYTE, 1'b0};
      bit_r <= '0;
    end else if (st_r == ST_TX) begin
      tx_r <= sh_r[0];
      if (period_done) begin
        sh_r <= {1'b1, sh_r[9:1]};
        bit_r <= bit_r + 4'h1;
      end
    end else if (st_r == ST_RX_BITS) begin
      tx_r <= 1'b1;
      // a full period after mid start lands in mid bit
      if (period_done) rxb_r <= {boot_serial_rx_line, rxb_r[7:1]};
      if (period_done) bit_r <= bit_r + 4'h1;
    end else begin
      tx_r <= 1'b1;
      bit_r <= '0;
    end
  end

  // received byte waits here while the buffer is full, holding off the next frame
  always_ff @(posedge sys_clk) begin
    if (!rst_b || st_r == ST_OFF) begin
      pend_r <= 1'b0;
      idx_r <= '0;
      pend_data_r <= '0;
    end else if (st_r == ST_RX_STOP && period_done) begin
      pend_r <= 1'b1;
      pend_data_r <= '{addr: LOAD_RAM_BASE + {18'h00000, idx_r}, data: rxb_r};
      idx_r <= idx_r + 6'h01;
    end else if (pend_r && buf_s_ready) begin
      pend_r <= 1'b0;
    end
  end

  sble_buf2 u_buf (
    .clk(sys_clk),
    .rst_b(rst_b),
    .s_valid(pend_r),
    .s_ready(buf_s_ready),
    .s_data(pend_data_r),
    .m_valid(ram_wr_valid),
    .m_ready(ram_wr_ready),
    .m_data(ram_wr)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      jump_r <= 1'b0;
      jump_addr_r <= LOAD_RAM_BASE;
      route_r <= ROUTE_FLASH;
      route_v_r <= 1'b0;
      cfg_r <= '{default: CFG_NORMAL};
    end else begin
      jump_r <= (st_r == ST_JUMP);
      jump_addr_r <= LOAD_RAM_BASE;
      route_r <= route_nxt;
      route_v_r <= fetch_valid;
      cfg_r <= mode_nxt ? sble_cfg_t'{SYSCFG_LOADER, SERCTL_LOADER, REGBANK_LOADER,
          STACK_LOADER, STACK_LOADER, STKOVF_LOADER} : sble_cfg_t'{default: CFG_NORMAL};
    end
  end

  assign boot_serial_tx_line = tx_r;
  assign tx_pin_direction_bit = mode_r;
  assign boot_loader_mode = mode_r;
  assign watchdog_disable = mode_r;
  assign cfg = cfg_r;
  assign baud_reload_value = brl_r;
  assign baud_overflow = ovf_r;
  assign fetch_route = route_r;
  assign fetch_route_valid = route_v_r;
  assign jump_req = jump_r;
  assign jump_addr = jump_addr_r;

  strap_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rel_pend_r && !sw_reset) |=> (boot_loader_mode == !$past(boot_select_pin)))
    else $error("loader mode does not follow strap at reset release");
  swrst_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sw_reset |=> !boot_loader_mode && st_r == ST_OFF)
    else $error("software reset did not leave loader mode");
  wdog_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    boot_loader_mode |-> watchdog_disable)
    else $error("watchdog enabled in loader mode");
  cfg_forced_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    boot_loader_mode |-> cfg.stack_overflow_limit == STKOVF_LOADER &&
      cfg.system_configuration == SYSCFG_LOADER && tx_pin_direction_bit)
    else $error("loader configuration not forced");
  code_redirect_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (boot_loader_mode && !sw_reset && fetch_is_code && in_flash)
      |=> fetch_route == ROUTE_BOOT_ROM)
    else $error("loader code fetch not sent to boot rom");
  romless_undef_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (boot_loader_mode && !sw_reset && !fetch_is_code && in_flash && !prog_mem_present)
      |=> fetch_route == ROUTE_UNDEF)
    else $error("romless data read not undefined");
  reload_calc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_r == ST_MEASURE && st_nxt == ST_TX)
      |=> baud_reload_value == ($past(t6_r) - RELOAD_SUB) / RELOAD_DIV)
    else $error("reload value not derived from timer");
  tx_silent_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_r != ST_TX) ##1 (st_r != ST_TX) |-> boot_serial_tx_line)
    else $error("transmit line active outside the id frame");
  load_range_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ram_wr_valid |-> ram_wr.addr >= LOAD_RAM_BASE && ram_wr.addr <= LOAD_RAM_LAST)
    else $error("start-up byte outside load area");
  jump_after_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    jump_req |-> idx_r == LOAD_BYTES && !ram_wr_valid)
    else $error("jump before all bytes stored");
  id_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_r == ST_MEASURE && st_nxt == ST_TX) |-> ##2 !boot_serial_tx_line)
    else $error("identification frame did not open with a start bit");
  store_order_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ram_wr_valid && ram_wr_ready) |=> !ram_wr_valid ||
      ram_wr.addr == $past(ram_wr.addr) + 24'h000001)
    else $error("start-up bytes stored out of order");
  data_to_flash_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (boot_loader_mode && !sw_reset && !fetch_is_code && in_flash && prog_mem_present)
      |=> fetch_route == ROUTE_FLASH)
    else $error("loader data read not sent to flash");
endmodule : sble_boot_loader
`default_nettype wire

// [tb/sble_host.sv]
// host model: sends the zero byte, reads the id byte, then sends the start-up bytes
`timescale 1ns/1ps
`default_nettype none
module sble_host #(
  parameter int BIT_CLKS = 64
) (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [255:0] payload,
  input wire logic dev_tx,
  output logic host_tx,
  output logic [7:0] id_seen,
  output logic id_done
);
  task automatic send(input logic [7:0] b, input int stop_clks);
    host_tx = 1'b0;
    repeat (BIT_CLKS) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      host_tx = b[i];
      repeat (BIT_CLKS) @(negedge sys_clk);
    end
    // idle line is pulled high between frames
    host_tx = 1'b1;
    repeat (stop_clks) @(negedge sys_clk);
  endtask : send

  task automatic recv;
    while (dev_tx !== 1'b0) @(negedge sys_clk);
    repeat (BIT_CLKS / 2) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(negedge sys_clk);
      id_seen[i] = dev_tx;
    end
    // let the device finish its stop bit before the line turns round
    repeat (2 * BIT_CLKS) @(negedge sys_clk);
  endtask : recv

  initial begin
    host_tx = 1'b1;
    id_seen = 8'h00;
    id_done = 1'b0;
    wait (go === 1'b1);
    @(negedge sys_clk);
    // no stop wait after the zero byte: the id frame starts at once
    send(8'h00, 0);
    recv;
    id_done = 1'b1;
    for (int i = 0; i < 32; i++) begin
      send(payload[i*8 +: 8], BIT_CLKS + 4);
    end
  end
endmodule : sble_host
`default_nettype wire

// [tb/sble_boot_loader_tb.sv]
// self-checking bench for the serial boot loader entry block
`timescale 1ns/1ps
`default_nettype none
module sble_boot_loader_tb;
  import sble_pkg::*;
  localparam int BIT_CLKS = 64;
  localparam logic [15:0] EXP_RELOAD = 16'((9 * BIT_CLKS / 4 - 36) / 72);
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic sys_clk, rst_b, sw_reset, boot_select_pin, external_access_pin, flash_seg1_map;
  logic prog_mem_present, host_tx, dev_tx, tx_dir, mode, wd_off, ovf, go, id_done, stall_en;
  logic fetch_valid, fetch_is_code, route_valid, ram_wr_valid, ram_wr_ready, jump_req;
  logic [23:0] fetch_addr, jump_addr;
  logic [15:0] reload;
  logic [7:0] id_seen;
  logic [255:0] payload;
  sble_cfg_t cfg;
  sble_route_t route;
  sble_ram_wr_t ram_wr;
  sble_route_t rt_q[$];
  sble_ram_wr_t wr_q[$];
  integer seed, fails, cmp_count, cycles;

  sble_boot_loader #(.ID_BYTE(ID)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .sw_reset(sw_reset), .boot_select_pin(boot_select_pin),
    .external_access_pin(external_access_pin), .flash_seg1_map(flash_seg1_map),
    .prog_mem_present(prog_mem_present), .boot_serial_rx_line(host_tx),
    .boot_serial_tx_line(dev_tx), .tx_pin_direction_bit(tx_dir), .boot_loader_mode(mode),
    .watchdog_disable(wd_off), .cfg(cfg), .baud_reload_value(reload), .baud_overflow(ovf),
    .fetch_valid(fetch_valid), .fetch_is_code(fetch_is_code), .fetch_addr(fetch_addr),
    .fetch_route(route), .fetch_route_valid(route_valid), .ram_wr_valid(ram_wr_valid),
    .ram_wr_ready(ram_wr_ready), .ram_wr(ram_wr), .jump_req(jump_req), .jump_addr(jump_addr));

  sble_host #(.BIT_CLKS(BIT_CLKS)) i_host (.sys_clk(sys_clk), .go(go), .payload(payload),
    .dev_tx(dev_tx), .host_tx(host_tx), .id_seen(id_seen), .id_done(id_done));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk_val(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_route(input sble_route_t got, input sble_route_t exp);
    chk_val({94'h0, got}, {94'h0, exp});
  endtask : chk_route

  task automatic chk_wr(input sble_ram_wr_t got, input sble_ram_wr_t exp);
    chk_val({64'h0, got}, {64'h0, exp});
  endtask : chk_wr

  task automatic close_out;
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  function automatic sble_route_t exp_route(input logic code, input logic [23:0] a,
      input logic s1, input logic pm, input logic ext, input logic md);
    logic win;
    win = s1 ? (a >= FLASH_SEG1_LO && a <= FLASH_SEG1_HI) : (a <= FLASH_SEG0_HI);
    if (!win) return ROUTE_EXTERNAL;
    if (!md) return ext ? ROUTE_FLASH : ROUTE_EXTERNAL;
    if (code) return ROUTE_BOOT_ROM;
    return pm ? ROUTE_FLASH : ROUTE_UNDEF;
  endfunction : exp_route

  // random fetches around both flash windows; each expectation is queued as it is driven
  task automatic run_fetches(input int n, input logic md);
    for (int i = 0; i < n; i++) begin
      fetch_valid = 1'b1;
      fetch_is_code = 1'($random(seed));
      fetch_addr = {7'h00, 1'($random(seed)), 16'($random(seed))};
      flash_seg1_map = 1'($random(seed));
      external_access_pin = 1'($random(seed));
      prog_mem_present = md ? 1'($random(seed)) : 1'b1;
      rt_q.push_back(exp_route(fetch_is_code, fetch_addr, flash_seg1_map, prog_mem_present,
        external_access_pin, md));
      @(negedge sys_clk);
    end
    fetch_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : run_fetches

  always @(posedge sys_clk) begin
    sble_route_t er;
    sble_ram_wr_t ew;
    er = sble_route_t'(2'bxx);
    ew = 'x;
    if (route_valid === 1'b1) begin
      if (rt_q.size() > 0) er = rt_q.pop_front();
      chk_route(route, er);
    end
    if (ram_wr_valid === 1'b1 && ram_wr_ready === 1'b1) begin
      if (wr_q.size() > 0) ew = wr_q.pop_front();
      chk_wr(ram_wr, ew);
    end
    cycles++;
    if (cycles == 60000) begin
      fails++;
      close_out;
    end
  end

  // receiver stalls at random so stored bytes wait at the buffer output, one entry at a time
  always @(negedge sys_clk) begin
    ram_wr_ready = stall_en ? (2'($random(seed)) != 2'h0) : 1'b1;
  end

  initial begin
    seed = 40343;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    rst_b = 1'b0;
    sw_reset = 1'b0;
    boot_select_pin = 1'b1;
    external_access_pin = 1'b1;
    flash_seg1_map = 1'b0;
    prog_mem_present = 1'b1;
    fetch_valid = 1'b0;
    fetch_is_code = 1'b0;
    fetch_addr = 24'h000000;
    go = 1'b0;
    stall_en = 1'b0;
    payload = '0;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_val({93'h0, mode, wd_off, tx_dir}, 96'h0);
    chk_val(cfg, {6{CFG_NORMAL}});
    run_fetches(30, 1'b0);
    rst_b = 1'b0;
    boot_select_pin = 1'b0;
    external_access_pin = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_val({92'h0, mode, wd_off, tx_dir, dev_tx}, 96'hf);
    chk_val(cfg, {SYSCFG_LOADER, SERCTL_LOADER, REGBANK_LOADER, STACK_LOADER, STACK_LOADER,
      STKOVF_LOADER});
    run_fetches(60, 1'b1);
    for (int i = 0; i < 32; i++) begin
      payload[i*8 +: 8] = 8'($random(seed));
      wr_q.push_back({LOAD_RAM_BASE + 24'(i), payload[i*8 +: 8]});
    end
    stall_en = 1'b1;
    go = 1'b1;
    for (int k = 0; k < 5000 && id_done !== 1'b1; k++) @(negedge sys_clk);
    if (id_done !== 1'b1) fails++;
    chk_val({80'h0, reload}, {80'h0, EXP_RELOAD});
    chk_val({88'h0, id_seen}, {88'h0, ID});
    chk_val({94'h0, ovf, tx_dir}, 96'h1);
    for (int k = 0; k < 40000 && jump_req !== 1'b1; k++) @(negedge sys_clk);
    if (jump_req !== 1'b1) fails++;
    chk_val({72'h0, jump_addr}, {72'h0, LOAD_RAM_BASE});
    chk_val({64'h0, 32'(wr_q.size())}, 96'h0);
    @(negedge sys_clk);
    chk_val({94'h0, jump_req, mode}, 96'h1);
    sw_reset = 1'b1;
    @(negedge sys_clk);
    sw_reset = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_val({95'h0, mode}, 96'h0);
    close_out;
  end
endmodule : sble_boot_loader_tb
`default_nettype wire
